// ---- bench/spc_card_model.sv ----
// Socket stand-in: the card detect pins seen by the power control bank.
// Assumes the bench chooses which detect contacts the card has reached.
`timescale 1ns/1ps
`default_nettype none
module spc_card_model (
  input  wire logic [1:0] seat,
  output logic      [1:0] card_detect_b
);
  // Pins are pulled up with no card; a contact that has met the card pulls low
  assign card_detect_b = ~seat;
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the socket power control bank over APB.
// Assumes the bank answers with pready and outputs settle two edges after a write.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // Signals and reference state
  // ****************************************************************
  localparam logic [9:0] A_REV = {spc_pkg::IDX_REV, 2'h0};
  localparam logic [9:0] A_PWR = {spc_pkg::IDX_PWR, 2'h0};
  localparam logic [9:0] A_SYS = {spc_pkg::IDX_SYS, 2'h0};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0]  seat = 2'h0;
  wire logic [1:0] card_detect_b;
  logic        pready, pslverr, card_output_gate;
  logic [31:0] prdata, rd;
  logic [1:0]  card_supply_level, prog_supply_request;
  logic        err;
  logic [7:0]  pwr_m = 8'h00;
  logic [7:0]  sys_m = 8'h00;
  logic [3:0]  rev_m = 4'h4;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  spc_top DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .card_detect_b(card_detect_b), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .card_output_gate(card_output_gate),
    .card_supply_level(card_supply_level), .prog_supply_request(prog_supply_request));
  spc_card_model partner (.seat(seat), .card_detect_b(card_detect_b));

  // Clock and a cycle ceiling far above the expected run length
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic legacy();
    return rev_m == spc_pkg::REV_LEGACY;
  endfunction

  // Bit 5 only takes a write in the legacy layout while the permit is set
  task automatic wr_pwr(input logic [7:0] d);
    logic [7:0] m;
    m = legacy() ? (sys_m[7] ? 8'hB3 : 8'h93) : 8'h9B;
    pwr_m = (pwr_m & ~m) | (d & m);
    apb(1'b1, A_PWR, {24'($urandom()), d});
  endtask

  task automatic wr_sys(input logic [7:0] d);
    sys_m = d & spc_pkg::MASK_SYS;
    apb(1'b1, A_SYS, {24'($urandom()), d});
    apb(1'b0, A_SYS, 32'h0);
    chk("sys read", 32'(sys_m), rd);
  endtask

  task automatic wr_rev(input logic [3:0] d);
    rev_m = d;
    apb(1'b1, A_REV, {28'($urandom()), d});
    apb(1'b0, A_REV, 32'h0);
    chk("rev read", 32'(rev_m), 32'(rd[3:0]));
  endtask

  // Let outputs settle, then compare pins and readback with the reference
  task automatic chk_out();
    logic [1:0] lvl, vpp;
    logic       on;
    repeat (6) @(posedge clk);
    if (legacy()) begin
      on = pwr_m[4] && !(pwr_m[5] && sys_m[7] && seat != 2'h3);
      lvl = on ? (sys_m[2] ? 2'h3 : 2'h2) : 2'h0;
    end else begin
      lvl = (pwr_m[4:3] == 2'h1) ? 2'h0 : pwr_m[4:3];
    end
    vpp = (lvl != 2'h0 && pwr_m[1:0] != 2'h3) ? pwr_m[1:0] : 2'h0;
    chk("gate", 32'(pwr_m[7]), 32'(card_output_gate));
    chk("level", 32'(lvl), 32'(card_supply_level));
    chk("prog", 32'(vpp), 32'(prog_supply_request));
    apb(1'b0, A_PWR, 32'h0);
    chk("pwr read", 32'(pwr_m & (legacy() ? 8'hB3 : 8'h9B)), rd);
    // Status word mirrors the applied supply state and the seated card
    apb(1'b0, {spc_pkg::IDX_STAT, 2'h0}, 32'h0);
    chk("status", 32'({seat == 2'h3, legacy() && pwr_m[5] && sys_m[7], 1'b0, pwr_m[7], lvl, vpp}), rd);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(80450));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, A_PWR, 32'h0);
    chk("pwr reset", 32'h0, rd);
    apb(1'b0, A_REV, 32'h0);
    chk("rev reset", 32'h4, 32'(rd[3:0]));
    chk_out();
    // Refused accesses leave the register alone
    apb(1'b1, 10'h3FC, 32'hFF);
    chk("unmapped err", 32'h1, 32'(err));
    apb(1'b1, A_PWR | 10'h1, 32'hFF);
    chk("misaligned err", 32'h1, 32'(err));
    chk_out();
    // All ones in each layout; permit off keeps bit 5 clear
    wr_pwr(8'hFF);
    chk_out();
    wr_rev(4'h2);
    wr_pwr(8'hFF);
    chk_out();
    // Auto switching with and without a seated card
    wr_sys(8'h80);
    wr_pwr(8'hB1);
    chk_out();
    seat <= 2'h1;
    chk_out();
    seat <= 2'h3;
    chk_out();
    wr_sys(8'h84);
    chk_out();
    wr_pwr(8'h82);
    chk_out();
    for (int i = 0; i < 150; i++) begin
      case ($urandom_range(3))
        0: wr_rev($urandom_range(1) ? 4'h2 : 4'($urandom()));
        1: wr_sys(8'($urandom()));
        2: seat <= 2'($urandom());
        default: wr_pwr(8'($urandom()));
      endcase
      chk_out();
    end
    // Reset in mid-run returns the bank to its power-on state
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    pwr_m = spc_pkg::PWR_RESET;
    sys_m = spc_pkg::SYS_RESET;
    rev_m = spc_pkg::REV_RESET;
    chk_out();
    apb(1'b0, A_REV, 32'h0);
    chk("rev after reset", 32'(spc_pkg::REV_RESET), 32'(rd[3:0]));
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- inc/spc_pkg.sv ----
// Constants for the socket power control register bank.
// Assumes a 40 MHz APB clock and byte addresses of four times the index.
package spc_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_REV  = 8'h00; // Revision field
  localparam logic [7:0] IDX_PWR  = 8'h02; // socket_power_control
  localparam logic [7:0] IDX_SYS  = 8'h20; // System control bits
  localparam logic [7:0] IDX_STAT = 8'h21; // Applied supply state

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GATE_BIT   = 7;
  localparam int AUTO_BIT   = 5;
  localparam int ON_BIT     = 4;
  localparam int LVL_LSB    = 3;
  localparam int VPP_LSB    = 0;
  localparam int PERMIT_BIT = 7;
  localparam int CHOICE_BIT = 2;

  // ****************************************************************
  // Reset values and write masks
  // ****************************************************************
  localparam logic [7:0] PWR_RESET  = 8'h00;
  localparam logic [7:0] SYS_RESET  = 8'h00;
  localparam logic [3:0] REV_RESET  = 4'h4;
  localparam logic [3:0] REV_LEGACY = 4'h2;
  localparam logic [7:0] MASK_LEG   = 8'hB3; // Bits 7,5,4,1,0
  localparam logic [7:0] MASK_EXT   = 8'h9B; // Bits 7,4,3,1,0
  localparam logic [7:0] MASK_SYS   = 8'h84; // Bits 7,2

  // ****************************************************************
  // Supply encodings
  // ****************************************************************
  localparam logic [1:0] VCC_OFF  = 2'h0;
  localparam logic [1:0] VCC_RSVD = 2'h1;
  localparam logic [1:0] VCC_5V   = 2'h2;
  localparam logic [1:0] VCC_3V3  = 2'h3;
  localparam logic [1:0] VPP_NONE = 2'h0;
  localparam logic [1:0] VPP_VCC  = 2'h1;
  localparam logic [1:0] VPP_12V  = 2'h2;
  localparam logic [1:0] VPP_RSVD = 2'h3;

endpackage

// ---- logic/spc_apb_slave.sv ----
// APB slave front end: one wait state, registered answer.
// Assumes an APB master that holds the request until pready is seen.
`timescale 1ns/1ps
`default_nettype none
module spc_apb_slave (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [spc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [spc_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                        hit,
  output logic                             pready,
  output logic      [spc_pkg::DATA_W-1:0]  prdata,
  output logic                             pslverr,
  output logic      [spc_pkg::IDX_W-1:0]   idx,
  output logic                             wr_stb
);

  // ****************************************************************
  // Handshake
  // ****************************************************************
  logic                       pready_d;
  logic                       pready_q;
  logic [spc_pkg::DATA_W-1:0] prdata_d;
  logic [spc_pkg::DATA_W-1:0] prdata_q;
  logic                       pslverr_d;
  logic                       pslverr_q;

  // Misaligned addresses never decode, so they fall to the error answer
  assign idx    = (paddr[1:0] == 2'h0) ? paddr[spc_pkg::ADDR_W-1:2] : 8'hFF;
  assign wr_stb = psel & penable & pready_q & pwrite & hit;

  // Answer one cycle into the access phase, then drop pready again
  always_comb begin
    pready_d  = psel & penable & ~pready_q;
    prdata_d  = (pready_d & ~pwrite & hit) ? rd_data : 32'h0000_0000;
    pslverr_d = pready_d & ~hit;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule
`default_nettype wire

// ---- logic/spc_supply_decode.sv ----
// Supply request decode from the stored register fields.
// Takes the raw stored register; each layout decodes only bits that its own mask keeps.
`timescale 1ns/1ps
`default_nettype none
module spc_supply_decode (
  input  wire logic       legacy,
  input  wire logic [7:0] pwr,
  input  wire logic       level_choice,
  input  wire logic       auto_on,
  input  wire logic       card_seated,
  output logic      [1:0] vcc_code,
  output logic      [1:0] vpp_code
);

  // ****************************************************************
  // Card supply, then programming supply
  // ****************************************************************
  logic on_legacy;
  logic vcc_live;

  // Auto switching cuts power while no card is seated
  assign on_legacy = pwr[spc_pkg::ON_BIT] & (~auto_on | card_seated);

  always_comb begin
    if (legacy) begin
      if (on_legacy) begin
        vcc_code = level_choice ? spc_pkg::VCC_3V3 : spc_pkg::VCC_5V; // R6
      end else begin
        vcc_code = spc_pkg::VCC_OFF; // R5
      end
    end else begin
      vcc_code = pwr[spc_pkg::LVL_LSB +: 2]; // R11
      if (vcc_code == spc_pkg::VCC_RSVD) begin
        vcc_code = spc_pkg::VCC_OFF;
      end
    end
  end

  // Reserved request is treated as no connection for safety
  always_comb begin
    vcc_live = (vcc_code == spc_pkg::VCC_5V) | (vcc_code == spc_pkg::VCC_3V3);
    vpp_code = pwr[spc_pkg::VPP_LSB +: 2]; // R8
    if (!vcc_live || vpp_code == spc_pkg::VPP_RSVD) begin // R9
      vpp_code = spc_pkg::VPP_NONE;
    end
  end

endmodule
`default_nettype wire

// ---- logic/spc_top.sv ----
// Socket power control register bank with APB access.
// Assumes card detect pins are asynchronous and active low.
//
// How it works
// (R1) Bit 7 gates all card-side outputs, off at reset, in both layouts; here it drives card_output_gate only, not the supply outputs.
// (R2) In the legacy layout bit 6 reads zero and cannot be written.
// (R3) In the legacy layout bit 5 enables card-detect driven supply switching.
// (R4) The auto switching bit only works while system control bit 7 permits.
// (R5) With legacy bit 4 clear, card and programming supplies are disconnected.
// (R6) With legacy bit 4 set, the card supply level comes from system bit 2.
// (R7) In the legacy layout bits 3 and 2 read zero.
// (R8) Bits 1:0 request programming supply none, card level, 12 V or reserved.
// (R9) The programming request is ignored unless the card supply is on.
// (R10) In the extended layout bits 6 and 5 read zero.
// (R11) In the extended layout bits 4:3 request 0 V, 0 V, 5 V or 3.3 V.
// (R12) In the extended layout bit 2 reads zero.
// (R13) Revision 0010b selects legacy; reset value 0100b selects extended.
// (R14) Writes to reserved bits or fields of the other layout do nothing.
`timescale 1ns/1ps
`default_nettype none
module spc_top (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [spc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [spc_pkg::DATA_W-1:0] pwdata,
  input  wire logic [1:0]                 card_detect_b,
  output logic                            pready,
  output logic      [spc_pkg::DATA_W-1:0] prdata,
  output logic                            pslverr,
  output logic                            card_output_gate,
  output logic      [1:0]                 card_supply_level,
  output logic      [1:0]                 prog_supply_request
);

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  logic [spc_pkg::DATA_W-1:0] rd_data;
  logic                       hit;
  logic [spc_pkg::IDX_W-1:0]  idx;
  logic                       wr_stb;

  spc_apb_slave u_apb (
    .clk     (clk),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .rd_data (rd_data),
    .hit     (hit),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .idx     (idx),
    .wr_stb  (wr_stb)
  );

  // ****************************************************************
  // Card detect synchroniser
  // ****************************************************************
  logic [1:0] cd_s1_q;
  logic [1:0] cd_s2_q;
  logic [1:0] cd_s3_q;
  logic [1:0] cd_stable_q;
  logic [1:0] cd_stable_d;

  // Three stages; a change counts only once stages two and three agree
  generate
    for (genvar i = 0; i < 2; i++) begin : g_cd
      always_comb begin
        cd_stable_d[i] = (cd_s2_q[i] == cd_s3_q[i]) ? cd_s3_q[i] : cd_stable_q[i];
      end
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cd_s1_q[i]     <= 1'b1;
          cd_s2_q[i]     <= 1'b1;
          cd_s3_q[i]     <= 1'b1;
          cd_stable_q[i] <= 1'b1;
        end else begin
          cd_s1_q[i]     <= card_detect_b[i];
          cd_s2_q[i]     <= cd_s1_q[i];
          cd_s3_q[i]     <= cd_s2_q[i];
          cd_stable_q[i] <= cd_stable_d[i];
        end
      end
    end
  endgenerate

  // A partly inserted card is not seated; both detects must be low
  logic card_seated;
  assign card_seated = ~cd_stable_q[0] & ~cd_stable_q[1];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] pwr_q;
  logic [7:0] pwr_d;
  logic [7:0] sys_q;
  logic [7:0] sys_d;
  logic [3:0] rev_q;
  logic [3:0] rev_d;
  logic       legacy;
  logic       permit;
  logic [7:0] pwr_mask;
  logic [7:0] pwr_view;

  assign legacy = (rev_q == spc_pkg::REV_LEGACY); // R13
  assign permit = sys_q[spc_pkg::PERMIT_BIT];

  // Writable bits follow the active layout; bit 5 also needs the permit
  always_comb begin
    pwr_mask = legacy ? spc_pkg::MASK_LEG : spc_pkg::MASK_EXT; // R2 R7 R10 R12 R14
    if (!permit) begin
      pwr_mask[spc_pkg::AUTO_BIT] = 1'b0; // R4
    end
  end

  // Readback hides bits that the active layout does not own
  assign pwr_view = pwr_q & (legacy ? spc_pkg::MASK_LEG : spc_pkg::MASK_EXT); // R2 R7 R10 R12

  // Next values; a masked merge leaves reserved bits untouched
  always_comb begin
    pwr_d = pwr_q;
    sys_d = sys_q;
    rev_d = rev_q;
    if (wr_stb) begin
      case (idx)
        spc_pkg::IDX_PWR: begin
          pwr_d = (pwr_q & ~pwr_mask) | (pwdata[7:0] & pwr_mask); // R14
        end
        spc_pkg::IDX_SYS: begin
          sys_d = pwdata[7:0] & spc_pkg::MASK_SYS;
        end
        spc_pkg::IDX_REV: begin
          rev_d = pwdata[3:0]; // R13
        end
        default: begin
          pwr_d = pwr_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pwr_q <= spc_pkg::PWR_RESET;
      sys_q <= spc_pkg::SYS_RESET;
      rev_q <= spc_pkg::REV_RESET; // R13
    end else begin
      pwr_q <= pwr_d;
      sys_q <= sys_d;
      rev_q <= rev_d;
    end
  end

  // ****************************************************************
  // Supply decode
  // ****************************************************************
  logic       auto_on;
  logic [1:0] vcc_code;
  logic [1:0] vpp_code;

  // Auto switching is a legacy feature and needs the system permit
  assign auto_on = legacy & pwr_q[spc_pkg::AUTO_BIT] & permit; // R3 R4

  spc_supply_decode u_dec (
    .legacy       (legacy),
    .pwr          (pwr_q),
    .level_choice (sys_q[spc_pkg::CHOICE_BIT]),
    .auto_on      (auto_on),
    .card_seated  (card_seated),
    .vcc_code     (vcc_code),
    .vpp_code     (vpp_code)
  ); // R5 R6 R8 R9 R11

  // ****************************************************************
  // Outputs, registered so the switch never sees decode glitches
  // ****************************************************************
  logic       gate_d;
  logic       gate_q;
  logic [1:0] vcc_q;
  logic [1:0] vpp_q;

  always_comb begin
    gate_d = pwr_q[spc_pkg::GATE_BIT]; // R1
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gate_q <= 1'b0;
      vcc_q  <= spc_pkg::VCC_OFF;
      vpp_q  <= spc_pkg::VPP_NONE;
    end else begin
      gate_q <= gate_d;
      vcc_q  <= vcc_code;
      vpp_q  <= vpp_code;
    end
  end

  assign card_output_gate    = gate_q;
  assign card_supply_level   = vcc_q;
  assign prog_supply_request = vpp_q;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0000_0000;
    case (idx)
      spc_pkg::IDX_PWR:  rd_data[7:0] = pwr_view;
      spc_pkg::IDX_SYS:  rd_data[7:0] = sys_q;
      spc_pkg::IDX_REV:  rd_data[3:0] = rev_q;
      spc_pkg::IDX_STAT: rd_data[7:0] = {card_seated, auto_on, 1'b0, gate_q,
                                         vcc_q, vpp_q};
      default:           hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_pwr_write;
    wr_stb && idx == spc_pkg::IDX_PWR;
  endsequence

  sequence s_applied;
    ##2 1'b1;
  endsequence

  chk_gate_follows: assert property ( // R1
    s_pwr_write |-> s_applied ##0 card_output_gate == $past(pwdata[7], 2))
    else $error("Output gate does not follow bit 7");

  // Watch the bus answer itself, so a broken read path is caught too
  chk_legacy_rsvd: assert property ( // R2 R7
    pready && idx == spc_pkg::IDX_PWR && legacy |-> prdata[6] == 1'b0 && prdata[3:2] == 2'h0)
    else $error("Legacy reserved bits read nonzero");

  chk_ext_rsvd: assert property ( // R10 R12
    pready && idx == spc_pkg::IDX_PWR && !legacy |-> prdata[6:5] == 2'h0 && prdata[2] == 1'b0)
    else $error("Extended reserved bits read nonzero");

  chk_rsvd_keep: assert property ( // R14
    s_pwr_write |=> pwr_q[6] == $past(pwr_q[6]) && pwr_q[2] == $past(pwr_q[2])
      && ($past(legacy) ? pwr_q[3] == $past(pwr_q[3]) : pwr_q[5] == $past(pwr_q[5])))
    else $error("Write changed a reserved or foreign bit");

  chk_auto_permit: assert property ( // R4
    s_pwr_write ##0 !permit |=> pwr_q[5] == $past(pwr_q[5]))
    else $error("Auto bit changed without permit");

  chk_auto_cut: assert property ( // R3
    auto_on && !card_seated |=> card_supply_level == spc_pkg::VCC_OFF)
    else $error("Auto switching left supply on without a card");

  chk_legacy_off: assert property ( // R5
    legacy && !pwr_q[4] |=> card_supply_level == spc_pkg::VCC_OFF
                         && prog_supply_request == spc_pkg::VPP_NONE)
    else $error("Supplies on with power enable clear");

  chk_legacy_level: assert property ( // R6
    legacy && pwr_q[4] && !auto_on && sys_q[2] |=> card_supply_level == spc_pkg::VCC_3V3)
    else $error("Legacy level ignores system choice");

  chk_vpp_ignored: assert property ( // R9
    card_supply_level == spc_pkg::VCC_OFF |-> prog_supply_request == spc_pkg::VPP_NONE)
    else $error("Programming supply on without card supply");

  chk_vpp_pass: assert property ( // R8
    vcc_code != spc_pkg::VCC_OFF && pwr_q[1:0] == spc_pkg::VPP_12V
      |=> prog_supply_request == spc_pkg::VPP_12V)
    else $error("Programming 12 V request lost");

  chk_ext_level: assert property ( // R11
    !legacy && pwr_q[4:3] == spc_pkg::VCC_RSVD |=> card_supply_level == spc_pkg::VCC_OFF)
    else $error("Reserved level not treated as 0 V");

  chk_layout_sel: assert property ( // R13
    wr_stb && idx == spc_pkg::IDX_REV && pwdata[3:0] == spc_pkg::REV_LEGACY |=> legacy)
    else $error("Revision write did not select legacy");

  chk_bus_answer: assert property (
    psel && !penable ##1 psel && penable |=> pready)
    else $error("Slave did not answer after one wait");

endmodule
`default_nettype wire
